// [bench/ecpm_periph.sv]
// cable peripheral model: takes forward bytes, sends reverse bytes
`timescale 1ns/100ps
`default_nettype none

module ecpm_periph (
  input  wire logic       i_clk,
  input  wire logic       i_nstrobe,
  input  wire logic       i_nautofd,
  input  wire logic [7:0] i_pd,
  input  wire logic       i_slow,
  input  wire logic       i_rgo,
  input  wire logic [8:0] i_rbyte,
  output logic      [7:0] o_pd,
  output logic            o_busy,
  output logic            o_nack,
  output logic      [7:0] o_got,
  output logic            o_tag,
  output logic      [7:0] o_cnt,
  output logic      [7:0] o_rsent
);
  logic [7:0] last;
  logic       drv;

  // released lines show the inverse of the last byte, never a stale copy
  assign o_pd = drv ? last : ~last;

  task automatic pause();
    repeat (i_slow ? 20 : 3) @(posedge i_clk);
  endtask

  // one handshake at a time, so busy has a single driver
  initial begin
    {o_busy, o_tag, drv, last, o_got, o_cnt, o_rsent} = '0;
    o_nack = 1'b1;
    forever begin
      @(posedge i_clk);
      if (!i_nstrobe) begin
        o_got <= i_pd;
        o_tag <= i_nautofd;
        pause();
        o_busy <= 1'b1;
        o_cnt <= o_cnt + 8'h01;
        @(posedge i_clk iff i_nstrobe);
        pause();
        o_busy <= 1'b0;
      end else if (i_rgo && !i_nautofd) begin
        last <= i_rbyte[7:0];
        drv <= 1'b1;
        o_busy <= ~i_rbyte[8];
        pause();
        o_nack <= 1'b0;
        @(posedge i_clk iff i_nautofd);
        pause();
        o_nack <= 1'b1;
        drv <= 1'b0;
        o_rsent <= o_rsent + 8'h01;
        pause();
        o_busy <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// [bench/tb_top.sv]
// testbench of the port mode control with a cable peripheral
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic        clk, rstn, wr, rd, epp_en, pd_oe, busy, nack, epp_act, slow, rgo, tag;
  logic [10:0] addr;
  logic [7:0]  wdata, rdata, pd_o, pd_p, got, cnt, rsent, base;
  logic        nstb_o, nstb_oe, naf_o, naf_oe, ninit_o, ninit_oe, nsel_o, nsel_oe;
  logic [8:0]  rbyte;
  int          mismatches, checks_done, cycles;

  ecpm_port ecpm_port_i (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wr(wr), .i_rd(rd),
    .i_wdata(wdata), .o_rdata(rdata), .i_epp_enable(epp_en), .i_irq_level(1'b0),
    .i_pd_i(pd_oe ? pd_o : pd_p), .o_pd_o(pd_o), .o_pd_oe(pd_oe), .i_busy(busy), .i_nack(nack),
    .i_perror(1'b0), .i_select(1'b1), .i_nfault(1'b1), .o_nstrobe_o(nstb_o),
    .o_nstrobe_oe(nstb_oe), .o_nautofd_o(naf_o), .o_nautofd_oe(naf_oe), .o_ninit_o(ninit_o),
    .o_ninit_oe(ninit_oe), .o_nselectin_o(nsel_o), .o_nselectin_oe(nsel_oe),
    .o_epp_active(epp_act));

  // control lines have cable pull-ups when not driven
  ecpm_periph ecpm_periph_i (.i_clk(clk), .i_nstrobe(nstb_oe ? nstb_o : 1'b1),
    .i_nautofd(naf_oe ? naf_o : 1'b1), .i_pd(pd_o), .i_slow(slow), .i_rgo(rgo), .i_rbyte(rbyte),
    .o_pd(pd_p), .o_busy(busy), .o_nack(nack), .o_got(got), .o_tag(tag), .o_cnt(cnt),
    .o_rsent(rsent));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %0t got %h want %h", $time, g, e);
      mismatches++;
    end
  endtask

  task automatic bus_wr(input logic [10:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    // one idle cycle so a following write never re-raises the strobe in the same step
    @(negedge clk);
  endtask

  task automatic bus_rd(input logic [10:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask

  // bounded wait on a partner counter
  task automatic wait_n(input bit rev, input logic [7:0] n);
    for (int i = 0; i < 3000 && (rev ? rsent : cnt) < n; i++) begin
      @(negedge clk);
    end
    chk(rev ? rsent : cnt, n);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_basic();
    bus_rd(11'h402, 8'h05);
    bus_wr(11'h002, 8'h01);
    repeat (2) @(negedge clk);
    chk({nstb_o, nstb_oe, naf_o, naf_oe, ninit_o, ninit_oe, nsel_o, nsel_oe}, 8'h66);
    bus_wr(11'h002, 8'h20);
    repeat (2) @(negedge clk);
    chk({nstb_o, nstb_oe, naf_o, naf_oe, ninit_o, ninit_oe, nsel_o, nsel_oe}, 8'hA6);
    bus_rd(11'h002, 8'h00);
    bus_wr(11'h000, 8'hC3);
    chk(pd_o, 8'hC3);
  endtask

  task automatic t_modes();
    bus_wr(11'h402, 8'hA4);
    bus_rd(11'h402, 8'h05);
    bus_wr(11'h402, 8'h84);
    chk(epp_act, 8'h00);
    epp_en = 1'b1;
    #1 chk(epp_act, 8'h01);
    @(negedge clk);
    bus_wr(11'h402, 8'hE4);
    bus_rd(11'h402, 8'h85);
    bus_wr(11'h402, 8'h04);
    bus_wr(11'h402, 8'hE4);
    bus_rd(11'h400, 8'h10);
    bus_rd(11'h401, 8'h00);
    bus_wr(11'h402, 8'h04);
  endtask

  // test mode: fill to the brim, overflow, drain, underrun, clear
  task automatic t_queue();
    base = cnt;
    bus_wr(11'h402, 8'hC4);
    for (int i = 0; i < 15; i++) bus_wr(11'h400, 8'(i));
    bus_rd(11'h402, 8'hC4);
    bus_wr(11'h400, 8'h0F);
    bus_rd(11'h402, 8'hC6);
    bus_wr(11'h400, 8'hFF);
    for (int i = 0; i < 16; i++) bus_rd(11'h400, 8'(i));
    bus_rd(11'h402, 8'hC5);
    bus_rd(11'h400, 8'h0F);
    chk(cnt, base);
    bus_wr(11'h400, 8'h77);
    bus_wr(11'h402, 8'h04);
    bus_rd(11'h402, 8'h05);
  endtask

  task automatic t_compat();
    slow = 1'b1;
    base = cnt;
    bus_wr(11'h402, 8'h44);
    bus_wr(11'h400, 8'h5A);
    bus_wr(11'h400, 8'hC3);
    wait_n(0, base + 8'h01);
    chk(got, 8'h5A);
    wait_n(0, base + 8'h02);
    chk(got, 8'hC3);
    bus_rd(11'h402, 8'h45);
    bus_wr(11'h402, 8'h24);
    slow = 1'b0;
  endtask

  task automatic t_fwd();
    base = cnt;
    bus_wr(11'h002, 8'h00);
    bus_wr(11'h402, 8'h64);
    bus_wr(11'h000, 8'h85);
    bus_wr(11'h400, 8'h3C);
    wait_n(0, base + 8'h01);
    chk({got[7:1], tag}, 8'h84);
    wait_n(0, base + 8'h02);
    chk({got[7:1], tag}, 8'h3D);
    bus_rd(11'h402, 8'h65);
    bus_wr(11'h402, 8'h24);
    // the all-idle pin cycle is the one right after the leave cycle
    chk({nstb_o, naf_o, ninit_o, nsel_o}, 8'h0F);
    @(negedge clk);
    chk(ninit_o, 8'h00);
  endtask

  // reverse: run count 2 then one data byte gives three copies
  task automatic t_rev();
    bus_wr(11'h002, 8'h20);
    bus_rd(11'h002, 8'h20);
    bus_wr(11'h402, 8'h64);
    rbyte = 9'h102;
    rgo = 1'b1;
    wait_n(1, 8'h01);
    rbyte = 9'h0A5;
    wait_n(1, 8'h02);
    rgo = 1'b0;
    repeat (6) @(negedge clk);
    bus_rd(11'h400, 8'hA5);
    bus_rd(11'h400, 8'hA5);
    chk(naf_o, 8'h00);
    bus_wr(11'h402, 8'h24);
    repeat (3) @(negedge clk);
    chk(naf_o, 8'h01);
    bus_rd(11'h402, 8'h25);
    chk(pd_oe, 8'h00);
    bus_rd(11'h000, 8'h5A);
    bus_wr(11'h402, 8'h04);
    chk(pd_oe, 8'h01);
  endtask

  // ----------------------------------------
  // clock, reset, sequence and timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    {rstn, wr, rd, epp_en, slow, rgo, addr, wdata, rbyte} = '0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_basic();
    t_modes();
    t_queue();
    t_compat();
    t_fwd();
    t_rev();
    finish_test();
  end
endmodule

`default_nettype wire

// [design/ecpm_fifo.sv]
// byte queue with a command tag bit, show-ahead head, honest full and empty
`timescale 1ns/100ps
`default_nettype none
`include "ecpm_regs.svh"

module ecpm_fifo (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_clr,
  input  wire logic       i_push,
  input  wire logic [8:0] i_wdata,
  input  wire logic       i_pop,
  output logic      [8:0] o_head,
  output logic            o_full,
  output logic            o_empty,
  output logic      [4:0] o_count
);

  logic [8:0]               mem [0:15];
  logic [`ECPM_FIFO_AW-1:0] wr_ptr_reg;
  logic [`ECPM_FIFO_AW-1:0] rd_ptr_reg;
  logic [4:0]               cnt_reg;

  // push into a full queue and pop from an empty one are dropped
  wire logic do_push = i_push && !o_full;
  wire logic do_pop  = i_pop && !o_empty;

  assign o_full  = (cnt_reg == `ECPM_FIFO_DEPTH);
  assign o_empty = (cnt_reg == 5'h00);
  assign o_count = cnt_reg;
  assign o_head  = mem[rd_ptr_reg];

  // storage has no reset; only the pointers define the contents
  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= i_wdata;
    end
  end

  // pointers and occupancy, clear wins over both sides
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      cnt_reg    <= 5'h00;
    end else if (i_clr) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      cnt_reg    <= 5'h00;
    end else begin
      if (do_push) wr_ptr_reg <= wr_ptr_reg + 4'h1;
      if (do_pop) rd_ptr_reg <= rd_ptr_reg + 4'h1;
      cnt_reg <= cnt_reg + {4'h0, do_push} - {4'h0, do_pop};
    end
  end

endmodule

`default_nettype wire

// [design/ecpm_pkg.sv]
// types shared by the parallel port mode control files
package ecpm_pkg;

  typedef enum logic [2:0] {
    ECPM_SPP   = 3'b000,
    ECPM_PS2   = 3'b001,
    ECPM_CFIFO = 3'b010,
    ECPM_ECP   = 3'b011,
    ECPM_EPP   = 3'b100,
    ECPM_RSVD  = 3'b101,
    ECPM_TEST  = 3'b110,
    ECPM_CFG   = 3'b111
  } ecpm_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_C_SETUP = 4'b0001,
    ST_C_STB   = 4'b0010,
    ST_C_BUSY  = 4'b0011,
    ST_F_SETUP = 4'b0100,
    ST_F_STB   = 4'b0101,
    ST_F_REL   = 4'b0110,
    ST_R_READY = 4'b0111,
    ST_R_ACK   = 4'b1000,
    ST_R_REP   = 4'b1001
  } ecpm_state_e;

endpackage

// [design/ecpm_port.sv]
// parallel port mode field, queue control and automatic handshakes
`timescale 1ns/100ps
`default_nettype none
`include "ecpm_regs.svh"

module ecpm_port import ecpm_pkg::*; (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [10:0] i_addr,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_epp_enable,
  input  wire logic        i_irq_level,
  input  wire logic [7:0]  i_pd_i,
  output logic      [7:0]  o_pd_o,
  output logic             o_pd_oe,
  input  wire logic        i_busy,
  input  wire logic        i_nack,
  input  wire logic        i_perror,
  input  wire logic        i_select,
  input  wire logic        i_nfault,
  output logic             o_nstrobe_o,
  output logic             o_nstrobe_oe,
  output logic             o_nautofd_o,
  output logic             o_nautofd_oe,
  output logic             o_ninit_o,
  output logic             o_ninit_oe,
  output logic             o_nselectin_o,
  output logic             o_nselectin_oe,
  output logic             o_epp_active
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [13:0] sync1_reg;
  logic [13:0] sync2_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_reg <= 14'h0000;
      sync2_reg <= 14'h0000;
    end else begin
      sync1_reg <= {i_irq_level, i_nfault, i_select, i_perror, i_nack, i_busy, i_pd_i};
      sync2_reg <= sync1_reg;
    end
  end

  wire logic [7:0] pd_s     = sync2_reg[7:0];
  wire logic       busy_s   = sync2_reg[8];
  wire logic       nack_s   = sync2_reg[9];
  wire logic       perror_s = sync2_reg[10];
  wire logic       select_s = sync2_reg[11];
  wire logic       nfault_s = sync2_reg[12];
  wire logic       irq_s    = sync2_reg[13];

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  ecpm_mode_e  mode_reg;
  ecpm_mode_e  pend_reg;
  ecpm_state_e state_reg;
  ecpm_state_e state_next;
  logic        leave_reg;
  logic        dir_reg;
  logic [4:0]  dcr_reg;
  logic [2:0]  ecr_lo_reg;
  logic [7:0]  data_reg;
  logic [7:0]  last_reg;
  logic [7:0]  tmr_reg;
  logic [7:0]  tmr_next;
  logic [7:0]  tx_reg;
  logic [7:0]  tx_next;
  logic        hack_reg;
  logic        hack_next;
  logic [7:0]  rx_reg;
  logic [7:0]  rx_next;
  logic        rxcmd_reg;
  logic        rxcmd_next;
  logic [6:0]  rle_reg;
  logic [6:0]  rle_next;
  logic        rlev_reg;
  logic        rlev_next;
  logic [6:0]  rep_reg;
  logic [6:0]  rep_next;
  logic        fsm_push;
  logic        fsm_pop;
  logic [7:0]  rdata_next;
  logic [8:0]  fifo_head;
  logic        fifo_full;
  logic        fifo_empty;
  logic [4:0]  fifo_cnt;

  // ----------------------------------------
  // mode and address decode
  // ----------------------------------------
  ecpm_mode_e  new_mode;
  assign new_mode = ecpm_mode_e'(i_wdata[`ECPM_ECR_MODE_HI:`ECPM_ECR_MODE_LO]);
  wire logic is_spp    = (mode_reg == ECPM_SPP);
  wire logic is_ps2    = (mode_reg == ECPM_PS2);
  wire logic is_cfifo  = (mode_reg == ECPM_CFIFO);
  wire logic is_ecp    = (mode_reg == ECPM_ECP);
  wire logic is_test   = (mode_reg == ECPM_TEST);
  wire logic is_cfg    = (mode_reg == ECPM_CFG);
  wire logic cur_basic = is_spp || is_ps2;
  wire logic new_basic = (new_mode == ECPM_SPP) || (new_mode == ECPM_PS2);
  wire logic fwd_ecp   = is_ecp && !dir_reg;
  wire logic rev_ecp   = is_ecp && dir_reg;
  wire logic xfer_run  = (is_cfifo || is_ecp) && !leave_reg;
  wire logic wr_data   = i_wr && (i_addr == `ECPM_A_DATA);
  wire logic wr_dcr    = i_wr && (i_addr == `ECPM_A_DCR);
  wire logic wr_fifo   = i_wr && (i_addr == `ECPM_A_FIFO);
  wire logic wr_ecr    = i_wr && (i_addr == `ECPM_A_ECR);
  wire logic rd_fifo   = i_rd && (i_addr == `ECPM_A_FIFO);
  // reserved code refused; extended modes return only to basic ones
  wire logic ecr_legal = wr_ecr && (new_mode != ECPM_RSVD) && (cur_basic || new_basic);
  wire logic leave_go  = ecr_legal && new_basic && (is_cfifo || is_ecp);
  // command port writes count only in forward ECP, data port in 010, forward ECP and test mode
  wire logic cmd_push  = wr_data && fwd_ecp;
  wire logic host_push = (wr_fifo && (is_cfifo || fwd_ecp || is_test)) || cmd_push;
  wire logic host_pop  = rd_fifo && (rev_ecp || is_test);
  wire logic fifo_clr  = is_spp || (leave_reg && rev_ecp);
  wire logic fifo_push = host_push || fsm_push;
  wire logic fifo_pop  = host_pop || fsm_pop;
  wire logic [8:0] fifo_wdata = fsm_push ? {1'b0, rx_reg} : {cmd_push, i_wdata};
  assign o_epp_active = (mode_reg == ECPM_EPP) && i_epp_enable;

  ecpm_fifo u_fifo (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_clr   (fifo_clr),
    .i_push  (fifo_push),
    .i_wdata (fifo_wdata),
    .i_pop   (fifo_pop),
    .o_head  (fifo_head),
    .o_full  (fifo_full),
    .o_empty (fifo_empty),
    .o_count (fifo_cnt)
  );

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // a leave takes two steps so the controls idle before the new mode
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_reg   <= ECPM_SPP;
      pend_reg   <= ECPM_SPP;
      leave_reg  <= 1'b0;
      dir_reg    <= 1'b0;
      dcr_reg    <= `ECPM_DCR_RST;
      ecr_lo_reg <= `ECPM_ECR_LO_RST;
      data_reg   <= 8'h00;
      last_reg   <= 8'h00;
    end else begin
      if (leave_reg) begin
        mode_reg  <= pend_reg;
        leave_reg <= 1'b0;
      end else if (leave_go) begin
        pend_reg  <= new_mode;
        leave_reg <= 1'b1;
      end else if (ecr_legal) begin
        mode_reg <= new_mode;
      end
      if (wr_ecr) ecr_lo_reg <= i_wdata[4:2];
      if (wr_dcr) dcr_reg <= i_wdata[4:0];
      if (wr_dcr && is_ps2) dir_reg <= i_wdata[`ECPM_DCR_DIR];
      if (wr_data && !is_ecp) data_reg <= i_wdata;
      if (host_pop && !fifo_empty) last_reg <= fifo_head[7:0];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // an empty queue read in test mode returns the last byte again
  always_comb begin
    rdata_next = 8'h00;
    case (i_addr)
      `ECPM_A_DATA: rdata_next = is_ps2 ? pd_s : data_reg;
      `ECPM_A_DSR:  rdata_next = {~busy_s, nack_s, perror_s, select_s, nfault_s, 3'h0};
      `ECPM_A_DCR:  rdata_next = {2'h0, dir_reg, dcr_reg};
      `ECPM_A_FIFO: rdata_next = is_cfg ? `ECPM_CFGA_VAL : (fifo_empty ? last_reg : fifo_head[7:0]);
      `ECPM_A_CFGB: rdata_next = is_cfg ? {1'b0, irq_s, 6'h00} : 8'h00;
      `ECPM_A_ECR:  rdata_next = {mode_reg, ecr_lo_reg, fifo_full, fifo_empty};
      default:      rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end
  end

  // ----------------------------------------
  // automatic handshake
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    tmr_next   = (tmr_reg == 8'h00) ? 8'h00 : tmr_reg - 8'h01;
    tx_next    = tx_reg;
    hack_next  = hack_reg;
    rx_next    = rx_reg;
    rxcmd_next = rxcmd_reg;
    rle_next   = rle_reg;
    rlev_next  = rlev_reg;
    rep_next   = rep_reg;
    fsm_push   = 1'b0;
    fsm_pop    = 1'b0;
    if (!xfer_run) begin
      state_next = ST_IDLE;
      rlev_next  = 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (is_cfifo && !fifo_empty && !busy_s) begin
            fsm_pop    = 1'b1;
            tx_next    = fifo_head[7:0];
            tmr_next   = 8'(`ECPM_STB_CYC);
            state_next = ST_C_SETUP;
          end else if (fwd_ecp && !fifo_empty) begin
            fsm_pop    = 1'b1;
            tx_next    = fifo_head[7:0];
            hack_next  = !fifo_head[8];
            state_next = ST_F_SETUP;
          end else if (rev_ecp && !fifo_full) begin
            state_next = ST_R_READY;
          end
        end
        ST_C_SETUP: begin
          if (tmr_reg == 8'h00) begin
            tmr_next   = 8'(`ECPM_STB_CYC);
            state_next = ST_C_STB;
          end
        end
        ST_C_STB:   if (tmr_reg == 8'h00) state_next = ST_C_BUSY;
        ST_C_BUSY:  if (!busy_s) state_next = ST_IDLE;
        ST_F_SETUP: if (!busy_s) state_next = ST_F_STB;
        ST_F_STB:   if (busy_s) state_next = ST_F_REL;
        ST_F_REL:   state_next = ST_IDLE;
        ST_R_READY: begin
          if (!nack_s) begin
            rx_next    = pd_s;
            rxcmd_next = !busy_s;
            state_next = ST_R_ACK;
          end
        end
        ST_R_ACK: begin
          if (nack_s) begin
            state_next = ST_IDLE;
            if (rxcmd_reg) begin
              // channel addresses in reverse are dropped
              if (!rx_reg[7]) begin
                rle_next  = rx_reg[6:0];
                rlev_next = 1'b1;
              end
            end else begin
              fsm_push  = 1'b1;
              rlev_next = 1'b0;
              if (rlev_reg && (rle_reg != 7'h00)) begin
                rep_next   = rle_reg;
                state_next = ST_R_REP;
              end
            end
          end
        end
        ST_R_REP: begin
          // repeats stall on a full queue until the host reads
          if (!fifo_full) begin
            fsm_push = 1'b1;
            rep_next = rep_reg - 7'h01;
            if (rep_reg == 7'h01) state_next = ST_IDLE;
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
      tmr_reg   <= 8'h00;
      tx_reg    <= 8'h00;
      hack_reg  <= 1'b1;
      rx_reg    <= 8'h00;
      rxcmd_reg <= 1'b0;
      rle_reg   <= 7'h00;
      rlev_reg  <= 1'b0;
      rep_reg   <= 7'h00;
    end else begin
      state_reg <= state_next;
      tmr_reg   <= tmr_next;
      tx_reg    <= tx_next;
      hack_reg  <= hack_next;
      rx_reg    <= rx_next;
      rxcmd_reg <= rxcmd_next;
      rle_reg   <= rle_next;
      rlev_reg  <= rlev_next;
      rep_reg   <= rep_next;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // registered so a state change cannot glitch a handshake line
  wire logic stb_low  = (state_reg == ST_C_STB) || (state_reg == ST_F_STB);
  wire logic fsm_afd  = rev_ecp ? (state_reg != ST_R_READY) : (fwd_ecp ? hack_reg : 1'b1);
  wire logic nstb_v   = leave_reg ? 1'b1 : (xfer_run ? !stb_low : !dcr_reg[`ECPM_DCR_STROBE]);
  wire logic nafd_v   = leave_reg ? 1'b1 : (xfer_run ? fsm_afd : !dcr_reg[`ECPM_DCR_AUTO_LINEFEED_BIT]);
  wire logic ninit_v  = leave_reg ? 1'b1 : dcr_reg[`ECPM_DCR_NINIT];
  wire logic nsel_v   = leave_reg ? 1'b1 : !dcr_reg[`ECPM_DCR_SELIN];
  // direction ignored in 000 and 010
  wire logic pd_oe_v  = !(dir_reg && !is_spp && !is_cfifo);
  wire logic [7:0] pd_v = (is_cfifo || fwd_ecp) ? tx_reg : data_reg;

  // open-collector in 000 drives only the low level
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pd_o         <= 8'h00;
      o_pd_oe        <= 1'b1;
      o_nstrobe_o    <= 1'b1;
      o_nstrobe_oe   <= 1'b0;
      o_nautofd_o    <= 1'b1;
      o_nautofd_oe   <= 1'b0;
      o_ninit_o      <= 1'b0;
      o_ninit_oe     <= 1'b1;
      o_nselectin_o  <= 1'b1;
      o_nselectin_oe <= 1'b0;
    end else begin
      o_pd_o         <= pd_v;
      o_pd_oe        <= pd_oe_v;
      o_nstrobe_o    <= nstb_v;
      o_nstrobe_oe   <= is_spp ? !nstb_v : 1'b1;
      o_nautofd_o    <= nafd_v;
      o_nautofd_oe   <= is_spp ? !nafd_v : 1'b1;
      o_ninit_o      <= ninit_v;
      o_ninit_oe     <= is_spp ? !ninit_v : 1'b1;
      o_nselectin_o  <= nsel_v;
      o_nselectin_oe <= is_spp ? !nsel_v : 1'b1;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_full_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
    fifo_full == (fifo_cnt == `ECPM_FIFO_DEPTH)) else $error("full flag wrong");
  chk_empty_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
    fifo_empty == (fifo_cnt == 5'h00)) else $error("empty flag wrong");
  chk_spp_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
    is_spp |=> fifo_empty && !fifo_full) else $error("queue not cleared in 000");
  chk_oc_drive: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $past(is_spp) |-> !(o_nstrobe_oe && o_nstrobe_o) && !(o_ninit_oe && o_ninit_o))
    else $error("control driven high in 000");
  chk_mode_lock: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (wr_ecr && !cur_basic && !new_basic && !leave_reg) |=> mode_reg == $past(mode_reg))
    else $error("illegal mode change taken");
  chk_dir_lock: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !is_ps2 |=> dir_reg == $past(dir_reg)) else $error("direction moved outside 001");
  chk_leave_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
    leave_reg |=> o_nstrobe_o && o_nautofd_o && o_ninit_o && o_nselectin_o)
    else $error("controls not idle on leave");
  chk_rev_afd: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (leave_reg && rev_ecp) |=> o_nautofd_o && fifo_empty) else $error("reverse leave not clean");
  chk_cfga_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_rd && is_cfg && i_addr == `ECPM_A_FIFO) |=> o_rdata == `ECPM_CFGA_VAL)
    else $error("config A read wrong");
  chk_test_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
    is_test |-> state_reg == ST_IDLE && !fsm_pop) else $error("handshake in test mode");
  chk_ps2_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_rd && is_ps2 && i_addr == `ECPM_A_DATA) |=> o_rdata == $past(pd_s))
    else $error("data read not from pins");

endmodule

`default_nettype wire

// [design/ecpm_regs.svh]
// register offsets, field positions, reset values and timing counts of the port
`ifndef ECPM_REGS_SVH
`define ECPM_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ECPM_A_DATA      11'h000
`define ECPM_A_DSR       11'h001
`define ECPM_A_DCR       11'h002
`define ECPM_A_FIFO      11'h400
`define ECPM_A_CFGB      11'h401
`define ECPM_A_ECR       11'h402

// ----------------------------------------
// field positions
// ----------------------------------------
`define ECPM_ECR_MODE_HI 7
`define ECPM_ECR_MODE_LO 5
`define ECPM_DCR_STROBE  0
`define ECPM_DCR_AUTO_LINEFEED_BIT  1
`define ECPM_DCR_NINIT   2
`define ECPM_DCR_SELIN   3
`define ECPM_DCR_DIR     5

// ----------------------------------------
// values and sizes
// ----------------------------------------
`define ECPM_CFGA_VAL    8'h10
`define ECPM_DCR_RST     5'h00
`define ECPM_ECR_LO_RST  3'h1
`define ECPM_FIFO_DEPTH  5'h10
`define ECPM_FIFO_AW     4

// ----------------------------------------
// timing: strobe setup and width
// ----------------------------------------
`define ECPM_CLK_NS      8
`define ECPM_STB_NS      500
`define ECPM_STB_CYC     ((`ECPM_STB_NS + `ECPM_CLK_NS - 1) / `ECPM_CLK_NS)

`endif
